// ---- logic/resizer_pointer_pkg.sv ----
// constants shared by the resizer pointer register slice
package resizer_pointer_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte offsets of the registers
  localparam logic [7:0] OFS_INPUT_FRAME_BASE_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_INPUT_LINE_PITCH = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_FRAME_BASE_ADDRESS = 8'h08;
  localparam logic [7:0] OFS_OUTPUT_LINE_PITCH = 8'h0c;
  localparam logic [7:0] OFS_HORIZONTAL_COEFFICIENT_PAIR = 8'h10;
  localparam logic [7:0] OFS_SOURCE_CONTROL = 8'h14;
  localparam logic [7:0] OFS_POINTER_STATUS = 8'h18;

  // pointer slots, one per address or pitch register
  localparam int NUM_SLOTS = 4;
  localparam int SLOT_IN_ADDR = 0;
  localparam int SLOT_IN_PITCH = 1;
  localparam int SLOT_OUT_ADDR = 2;
  localparam int SLOT_OUT_PITCH = 3;

  // per-slot offsets, index is the slot number
  localparam logic [NUM_SLOTS-1:0][7:0] SLOT_OFFSET = {
    OFS_OUTPUT_LINE_PITCH, OFS_OUTPUT_FRAME_BASE_ADDRESS,
    OFS_INPUT_LINE_PITCH, OFS_INPUT_FRAME_BASE_ADDRESS};

  // bits that a write may store (others hold zero)
  localparam logic [NUM_SLOTS-1:0][31:0] SLOT_STORE_MASK = {
    32'h0000_ffff, 32'hffff_ffff, 32'h0000_ffe0, 32'hffff_ffe0};

  // bits that reach the datapath (alignment bits are dropped)
  localparam logic [NUM_SLOTS-1:0][31:0] SLOT_ACTIVE_MASK = {
    32'h0000_ffe0, 32'hffff_ffe0, 32'h0000_ffe0, 32'hffff_ffe0};

  // every pointer register comes out of reset as zero
  localparam logic [31:0] POINTER_RESET = 32'h0000_0000;

  // line pitch is a 16-bit field
  localparam int PITCH_W = 16;

  // horizontal coefficient pair layout
  localparam int COEF_W = 10;
  localparam int ODD_TAP_LSB = 16;
  localparam int EVEN_TAP_LSB = 0;
  localparam int COEF_FRAC_BITS = 8;
  localparam logic [9:0] COEF_UNITY = 10'h100;
  localparam logic [9:0] COEF_RESET = 10'h000;

  // source control layout
  localparam int SRC_FROM_MEMORY_BIT = 0;
  localparam logic SRC_FROM_MEMORY_RESET = 1'b1;

  // pointer status layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PENDING_LSB = 1;
  localparam int STAT_SOURCE_ERROR_BIT = 5;
  localparam logic [3:0] PENDING_RESET = 4'h0;

endpackage

// ---- logic/pointer_slot.sv ----
// one base address or pitch register with a frame-boundary copy
`timescale 1ns/1ps
module pointer_slot #(
  parameter logic [31:0] STORE_MASK = 32'hffff_ffff,
  parameter logic [31:0] ACTIVE_MASK = 32'hffff_ffff
) (
  input wire logic clock, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic write_en, // software write this cycle
  input wire logic [31:0] write_data, // software write data
  input wire logic frame_start, // pulse at start of a frame
  output logic [31:0] latest, // newest written value
  output logic [31:0] active // value used by the current frame
);

  typedef struct packed {
    logic [31:0] latest;
    logic [31:0] active;
  } slot_s;

  slot_s state_reg;
  slot_s state_next;

  // store writes, copy into the frame value at frame start
  always_comb begin
    state_next = state_reg;
    if (write_en) begin
      state_next.latest = write_data & STORE_MASK;
    end
    if (frame_start) begin
      // a write in the same cycle goes straight into the new frame
      state_next.active = state_next.latest & ACTIVE_MASK;
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{latest: resizer_pointer_pkg::POINTER_RESET,
                     active: resizer_pointer_pkg::POINTER_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // reads see the newest value, the datapath the frame value
  assign latest = state_reg.latest;
  assign active = state_reg.active;

endmodule

// ---- logic/resizer_memory_pointer_regs.sv ----
// resizer memory pointer and horizontal coefficient register slice
`timescale 1ns/1ps
// Summary of operation
// - input base address low five bits zero
// - input pitch 16 bits, low five zero
// - pointer writes while busy apply next frame
// - output base address low five bits ignored
// - output pitch 16 bits, low five ignored
// - coefficient pair odd 25:16, even 9:0
// - coefficients signed ten bits, eight fractional
module resizer_memory_pointer_regs (
  input wire logic clock, // system clock, 10 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_write, // write strobe, one cycle
  input wire logic reg_read, // read strobe, one cycle
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic resizer_busy, // datapath is processing a frame
  input wire logic frame_start, // pulse, datapath starts a frame
  output logic [31:0] input_frame_base_address, // frame value
  output logic [15:0] input_line_pitch, // frame value
  output logic [31:0] output_frame_base_address, // frame value
  output logic [15:0] output_line_pitch, // frame value
  output logic signed [9:0] odd_tap_coefficient, // phase 0 odd tap
  output logic signed [9:0] even_tap_coefficient, // phase 0 even tap
  output logic input_from_memory, // input source is external memory
  output logic input_source_error // preview path with pointers set
);

  // register state other than the pointer slots
  typedef struct packed {
    logic [31:0] rdata;
    logic [9:0] odd_tap;
    logic [9:0] even_tap;
    logic from_memory;
    logic [3:0] pending;
  } regs_s;

  regs_s state_reg;
  regs_s state_next;

  // pointer slot views
  logic [3:0] slot_write;
  logic [3:0][31:0] slot_latest;
  logic [3:0][31:0] slot_active;

  // decoded strobes for the local registers
  logic coef_write;
  logic control_write;

  // status word assembled from live state
  logic [31:0] status_word;
  logic source_error;

  // read mux result for the addressed register
  logic [31:0] read_value;

  // one slot per address or pitch register
  genvar i;
  generate
    for (i = 0; i < resizer_pointer_pkg::NUM_SLOTS; i++) begin : g_slot
      // write decode for this slot
      assign slot_write[i] = reg_write &&
        (reg_addr == resizer_pointer_pkg::SLOT_OFFSET[i]);

      pointer_slot #(
        .STORE_MASK(resizer_pointer_pkg::SLOT_STORE_MASK[i]),
        .ACTIVE_MASK(resizer_pointer_pkg::SLOT_ACTIVE_MASK[i])
      ) u_slot (
        .clock(clock),
        .arst_n(arst_n),
        .write_en(slot_write[i]),
        .write_data(reg_wdata),
        .frame_start(frame_start),
        .latest(slot_latest[i]),
        .active(slot_active[i])
      );
    end
  endgenerate

  // write decode for the local registers
  assign coef_write = reg_write &&
    (reg_addr == resizer_pointer_pkg::OFS_HORIZONTAL_COEFFICIENT_PAIR);
  assign control_write = reg_write &&
    (reg_addr == resizer_pointer_pkg::OFS_SOURCE_CONTROL);

  // preview path must run with zero input pointers
  always_comb begin
    source_error = 1'b0;
    if (!state_reg.from_memory) begin
      source_error =
        (slot_active[resizer_pointer_pkg::SLOT_IN_ADDR] != '0) ||
        (slot_active[resizer_pointer_pkg::SLOT_IN_PITCH] != '0);
    end
  end

  // status word, unused bits read zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[resizer_pointer_pkg::STAT_BUSY_BIT] = resizer_busy;
    status_word[resizer_pointer_pkg::STAT_PENDING_LSB +: 4] =
      state_reg.pending;
    status_word[resizer_pointer_pkg::STAT_SOURCE_ERROR_BIT] = source_error;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (reg_addr)
      resizer_pointer_pkg::OFS_INPUT_FRAME_BASE_ADDRESS: begin
        read_value = slot_latest[resizer_pointer_pkg::SLOT_IN_ADDR];
      end
      resizer_pointer_pkg::OFS_INPUT_LINE_PITCH: begin
        read_value = slot_latest[resizer_pointer_pkg::SLOT_IN_PITCH];
      end
      resizer_pointer_pkg::OFS_OUTPUT_FRAME_BASE_ADDRESS: begin
        read_value = slot_latest[resizer_pointer_pkg::SLOT_OUT_ADDR];
      end
      resizer_pointer_pkg::OFS_OUTPUT_LINE_PITCH: begin
        read_value = slot_latest[resizer_pointer_pkg::SLOT_OUT_PITCH];
      end
      resizer_pointer_pkg::OFS_HORIZONTAL_COEFFICIENT_PAIR: begin
        // reserved 31:26 and 15:10 stay zero
        read_value[resizer_pointer_pkg::ODD_TAP_LSB +:
          resizer_pointer_pkg::COEF_W] = state_reg.odd_tap;
        read_value[resizer_pointer_pkg::EVEN_TAP_LSB +:
          resizer_pointer_pkg::COEF_W] = state_reg.even_tap;
      end
      resizer_pointer_pkg::OFS_SOURCE_CONTROL: begin
        read_value[resizer_pointer_pkg::SRC_FROM_MEMORY_BIT] =
          state_reg.from_memory;
      end
      resizer_pointer_pkg::OFS_POINTER_STATUS: begin
        read_value = status_word;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // next state of the local registers
  always_comb begin
    state_next = state_reg;

    // read data stands only in the cycle after the strobe
    state_next.rdata = 32'h0000_0000;
    if (reg_read) begin
      state_next.rdata = read_value;
    end

    // coefficients take effect at once, reserved bits dropped
    if (coef_write) begin
      state_next.odd_tap = reg_wdata[resizer_pointer_pkg::ODD_TAP_LSB +:
        resizer_pointer_pkg::COEF_W];
      state_next.even_tap = reg_wdata[resizer_pointer_pkg::EVEN_TAP_LSB +:
        resizer_pointer_pkg::COEF_W];
    end

    // input source selection
    if (control_write) begin
      state_next.from_memory =
        reg_wdata[resizer_pointer_pkg::SRC_FROM_MEMORY_BIT];
    end

    // pending clears at frame start, a later write sets it again
    if (frame_start) begin
      state_next.pending = 4'h0;
    end
    // a write in the frame start cycle is applied, so not pending
    if (!frame_start) begin
      state_next.pending = state_next.pending | slot_write;
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{rdata: 32'h0000_0000,
                     odd_tap: resizer_pointer_pkg::COEF_RESET,
                     even_tap: resizer_pointer_pkg::COEF_RESET,
                     from_memory: resizer_pointer_pkg::SRC_FROM_MEMORY_RESET,
                     pending: resizer_pointer_pkg::PENDING_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // bus read data
  assign reg_rdata = state_reg.rdata;

  // frame values to the datapath, alignment bits forced zero
  assign input_frame_base_address =
    slot_active[resizer_pointer_pkg::SLOT_IN_ADDR];
  assign input_line_pitch =
    slot_active[resizer_pointer_pkg::SLOT_IN_PITCH]
      [resizer_pointer_pkg::PITCH_W-1:0];
  assign output_frame_base_address =
    slot_active[resizer_pointer_pkg::SLOT_OUT_ADDR];
  assign output_line_pitch =
    slot_active[resizer_pointer_pkg::SLOT_OUT_PITCH]
      [resizer_pointer_pkg::PITCH_W-1:0];

  // coefficients as signed S10Q8, 10'h100 is unity gain
  assign odd_tap_coefficient = $signed(state_reg.odd_tap);
  assign even_tap_coefficient = $signed(state_reg.even_tap);

  // source selection and its consistency flag
  assign input_from_memory = state_reg.from_memory;
  assign input_source_error = source_error;

endmodule

// ---- tb/resizer_pointer_props.sv ----
// assertions on the resizer pointer register slice ports
`timescale 1ns/1ps
module resizer_pointer_props (
  input wire logic clock, // clock
  input wire logic arst_n, // reset
  input wire logic [7:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_write, // write strobe
  input wire logic reg_read, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic resizer_busy, // busy
  input wire logic frame_start, // frame pulse
  input wire logic [31:0] input_frame_base_address, // in base
  input wire logic [15:0] input_line_pitch, // in pitch
  input wire logic [31:0] output_frame_base_address, // out base
  input wire logic [15:0] output_line_pitch, // out pitch
  input wire logic signed [9:0] odd_tap_coefficient, // odd tap
  input wire logic signed [9:0] even_tap_coefficient, // even tap
  input wire logic input_from_memory, // source
  input wire logic input_source_error // source error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // alignment of the frame pointers
  in_base_low_a: assert property (
    input_frame_base_address[4:0] == 5'h0)
    else $error("input base not aligned");
  in_pitch_low_a: assert property (input_line_pitch[4:0] == 5'h0)
    else $error("input pitch not aligned");
  out_base_low_a: assert property (
    output_frame_base_address[4:0] == 5'h0)
    else $error("output base not aligned");
  out_pitch_low_a: assert property (
    output_line_pitch[4:0] == 5'h0)
    else $error("output pitch not aligned");
  // pointers move only at a frame start
  frame_hold_a: assert property (!frame_start |=>
    $stable(input_frame_base_address) && $stable(input_line_pitch) &&
    $stable(output_frame_base_address) && $stable(output_line_pitch))
    else $error("pointer changed without frame start");
  frame_apply_a: assert property (
    frame_start && reg_write &&
    reg_addr == 8'h08 |=> output_frame_base_address ==
    ($past(reg_wdata) & 32'hffff_ffe0)) else $error("frame value wrong");
  read_back_a: assert property (
    reg_write && reg_addr == 8'h00 ##1
    reg_read && reg_addr == 8'h00 |=> reg_rdata ==
    ($past(reg_wdata, 2) & 32'hffff_ffe0)) else $error("read back wrong");
  pitch_resv_a: assert property (reg_read &&
    (reg_addr == 8'h04 || reg_addr == 8'h0c) |=> reg_rdata[31:16] == 16'h0)
    else $error("pitch reserved bits set");
  coef_resv_a: assert property (reg_read && reg_addr == 8'h10 |=>
    reg_rdata[31:26] == 6'h0 && reg_rdata[15:10] == 6'h0)
    else $error("coefficient reserved bits set");
  coef_apply_a: assert property (
    reg_write && reg_addr == 8'h10 |=>
    {odd_tap_coefficient, even_tap_coefficient} ==
    {$past(reg_wdata[25:16]), $past(reg_wdata[9:0])})
    else $error("taps not applied");
  // main scenarios reached
  frame_write_c: cover property (frame_start && reg_write);
  coef_write_c: cover property (reg_write && reg_addr == 8'h10);
  busy_write_c: cover property (resizer_busy && reg_write);
  status_read_c: cover property (reg_read && reg_addr == 8'h18);
endmodule
bind resizer_memory_pointer_regs resizer_pointer_props props_i (.clock,
  .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .resizer_busy, .frame_start, .input_frame_base_address,
  .input_line_pitch, .output_frame_base_address, .output_line_pitch,
  .odd_tap_coefficient, .even_tap_coefficient, .input_from_memory,
  .input_source_error);

// ---- tb/testbench.sv ----
// self-checking bench for the resizer pointer register slice
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clock, arst_n, reg_write, reg_read, resizer_busy, frame_start;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, in_addr, out_addr;
  logic [15:0] in_pitch, out_pitch;
  logic signed [9:0] odd_tap, even_tap;
  logic from_mem, src_err;
  logic bz; // busy level driven with the last bus cycle
  logic [3:0] pend; // model of the pending bits
  logic [31:0] lat[5], act[4];
  logic [31:0] msk[5] = '{32'hffffffe0, 32'h0000ffe0, 32'hffffffff,
    32'h0000ffff, 32'h03ff03ff};
  logic [9:0] cv[4] = '{10'h200, 10'h100, 10'h1ff, 10'h3ff};
  int failures, checked;
  resizer_memory_pointer_regs dut (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .resizer_busy(resizer_busy),
    .frame_start(frame_start), .input_frame_base_address(in_addr),
    .input_line_pitch(in_pitch), .output_frame_base_address(out_addr),
    .output_line_pitch(out_pitch), .odd_tap_coefficient(odd_tap),
    .even_tap_coefficient(even_tap), .input_from_memory(from_mem),
    .input_source_error(src_err));
  // clock generator
  always #50 clock = ~clock;
  // one bus cycle, busy level random
  task bus(logic w, logic r, logic f, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_write <= w;
    reg_read <= r;
    frame_start <= f;
    reg_addr <= a;
    reg_wdata <= d;
    bz = 1'($urandom);
    resizer_busy <= bz;
  endtask
  // write slot s, model keeps latest and frame copies
  task wr(int s, logic [31:0] d, logic f);
    bus(1'b1, 1'b0, f, 8'(s * 4), d);
    if (s < 5) lat[s] = d & msk[s];
    if (f) for (int k = 0; k < 4; k++) act[k] = lat[k];
    if (f) pend = 4'h0;
    else if (s < 4) pend[s] = 1'b1;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    bus(1'b0, 1'b1, 1'b0, a, 32'h0);
    bus(1'b0, 1'b0, 1'b0, 8'h0, 32'h0);
    #1;
    `CHK("read data", e, reg_rdata)
  endtask
  // status read: busy as driven with the strobe, pending, error
  task st(logic e);
    logic b;
    bus(1'b0, 1'b1, 1'b0, 8'h18, 32'h0);
    b = bz;
    bus(1'b0, 1'b0, 1'b0, 8'h0, 32'h0);
    #1;
    `CHK("status", {26'h0, e, pend, b}, reg_rdata)
  endtask
  // frame outputs and tap coefficients against the model
  task outs;
    `CHK("in base", act[0], in_addr)
    `CHK("in pitch", act[1][15:0], in_pitch)
    `CHK("out base", act[2] & 32'hffffffe0, out_addr)
    `CHK("out pitch", act[3][15:0] & 16'hffe0, out_pitch)
    `CHK("odd taps", lat[4][25:16], odd_tap)
    `CHK("even taps", lat[4][9:0], even_tap)
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    int s;
    logic [31:0] d;
    clock = 1'b0;
    arst_n = 1'b0;
    {reg_write, reg_read, frame_start, resizer_busy} = 4'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    foreach (lat[i]) lat[i] = 32'h0;
    foreach (act[i]) act[i] = 32'h0;
    pend = 4'h0;
    bz = 1'b0;
    void'($urandom(9));
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      if (a != 6) begin
        rd(8'(a * 4), 32'(a == 5));
      end
    end
    st(1'b0);
    `CHK("from memory", 1'b1, from_mem)
    outs();
    $display("reset test done");
    repeat (30) begin
      s = $urandom_range(4);
      d = $urandom;
      wr(s, d, $urandom_range(2) == 0);
      rd(8'(s * 4), lat[s]);
      outs();
      st(1'b0);
    end
    $display("random pointer test done");
    foreach (cv[i]) begin
      wr(4, {6'h3f, cv[i], 6'h3f, ~cv[i]}, 1'b0);
      rd(8'h10, lat[4]);
      `CHK("odd tap", 32'($signed(cv[i])), 32'(odd_tap))
    end
    $display("coefficient test done");
    wr(5, 32'h0, 1'b0);
    wr(0, 32'h0, 1'b1);
    wr(1, 32'h0, 1'b1);
    rd(8'h14, 32'h0);
    `CHK("from memory", 1'b0, from_mem)
    `CHK("source error", 1'b0, src_err)
    wr(1, 32'h40, 1'b1);
    rd(8'h04, 32'h40);
    `CHK("source error", 1'b1, src_err)
    st(1'b1);
    wr(5, 32'h1, 1'b0);
    wr(7, 32'hffffffff, 1'b0);
    rd(8'h1c, 32'h0);
    `CHK("from memory", 1'b1, from_mem)
    outs();
    $display("source and unmapped test done");
    end_of_test();
  end
endmodule
